// ==== logic/spmc_regs.vh ====
`ifndef SPMC_REGS_VH
`define SPMC_REGS_VH

// Bit positions of each mode inside the mode word; the weight of a mode is 2**bit.
`define SPMC_BIT_QUIET      0
`define SPMC_BIT_COMPUTER   1
`define SPMC_BIT_PWGATE     2
`define SPMC_BIT_HWFLOW     3
`define SPMC_BIT_MULTIDROP  5
`define SPMC_BIT_MODEM      6
`define SPMC_BIT_PARFIX     7
`define SPMC_BIT_SWFLOW     8
`define SPMC_BIT_QUEUE      9
`define SPMC_BIT_RS485      10
`define SPMC_BIT_FRAME7E1   11
`define SPMC_BIT_PROMPT     12

// Width of the mode word.
`define SPMC_MODE_W         13

// Mask of the positions that hold a mode; bit 4 (weight 16) holds none.
`define SPMC_MODE_MASK      13'h1_FEF

// Reset value: parity fix, software flow control and the queue are on.
`define SPMC_MODE_RST       13'h0_380

// Flow-control characters.
`define SPMC_CHAR_XON       8'h11
`define SPMC_CHAR_XOFF      8'h13

// Default rate of the first serial port and the clock rate.
`define SPMC_BAUD_FIRST     19200
`define SPMC_CLK_HZ         100000000
`define SPMC_BAUD_DIV       (`SPMC_CLK_HZ / `SPMC_BAUD_FIRST)

`endif

// ==== logic/spmc_mode_cfg.v ====
`include "spmc_regs.vh"

// Synchronous FIFO with valid and ready on both sides.
module spmc_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  clk,
  nrst,
  in_data,
  in_valid,
  in_ready,
  out_data,
  out_valid,
  out_ready,
  one_deep
);
  input  wire             clk;
  input  wire             nrst;
  input  wire [WIDTH-1:0] in_data;
  input  wire             in_valid;
  output wire             in_ready;
  output reg  [WIDTH-1:0] out_data;
  output wire             out_valid;
  input  wire             out_ready;
  input  wire             one_deep;

  reg [WIDTH-1:0] mem [0:DEPTH-1];  // Storage words.
  reg [AW-1:0]    wr_ptr_ff;        // Next write slot.
  reg [AW-1:0]    rd_ptr_ff;        // Next read slot.
  reg [AW:0]      cnt_ff;           // Words held.

  wire full  = (cnt_ff == DEPTH) || (one_deep && (cnt_ff != 0));
  wire empty = (cnt_ff == 0);
  wire push  = in_valid && !full;
  wire pop   = out_ready && !empty;

  // Ready when a slot is free; in one-deep mode only while empty.
  assign in_ready  = !full;
  assign out_valid = !empty;

  // Pointers and count advance on each accepted push and pop.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff    <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  // The storage array itself carries no reset.
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // Read data is combinationally the head word.
  always @* begin
    out_data = mem[rd_ptr_ff];
  end
endmodule // spmc_fifo

// What this block does
// - Mode code is the weight sum.
// - Quiet drops unsolicited output, keeps requested.
// - Computer mode suppresses echo of received characters.
// - Password gate blocks all but help until a valid password arrives.
// - Framing bit selects 7E1 over 8N1.
// - RS-485 on second port beats multidrop.
// - Multidrop accepts only commands with own identifier.
// - Modem mode sends init string, raises lines.
// - Parity-fix enable flag drives the receiver.
// - Software flow control bit governs XON/XOFF.
// - Buffer bit enables full sixteen-word queue.
// - Prompt bit requests prompt in terminal mode.
// - Fix, flow and queue default on.
// - Each port keeps its own mode word.
// - First port defaults 19200 baud 8N1.
module spmc_mode_cfg #(
  parameter [9:0] OWN_ID = 10'h1_2D,  // Arbitrary default identifier.
  parameter       DEPTH  = 16,
  parameter       AW     = 4
) (
  clk,
  nrst,
  cfg_wr,
  cfg_port,
  cfg_mode,
  combined_config_code,
  tx_in_data,
  tx_in_solicited,
  tx_in_valid,
  tx_in_ready,
  tx_out_data,
  tx_out_parity,
  tx_out_valid,
  tx_out_ready,
  rx_char,
  rx_valid,
  echo_data,
  echo_valid,
  cmd_valid,
  cmd_is_help,
  cmd_id_present,
  cmd_id,
  pw_ok,
  cmd_accept,
  prompt_req,
  cts_in,
  dtr_out,
  rts_out,
  modem_init_req,
  rs485_en,
  multidrop_en,
  frame_7e1,
  parity_fix_enable,
  baud_div_first
);
  input  wire                       clk;
  input  wire                       nrst;
  input  wire                       cfg_wr;                // Write a mode word.
  input  wire                       cfg_port;              // 0 first_serial_port, 1 second_serial_port.
  input  wire [`SPMC_MODE_W-1:0]    cfg_mode;              // New mode word.
  output wire [2*`SPMC_MODE_W-1:0]  combined_config_code;  // Per-port weight sums.
  input  wire [15:0]                tx_in_data;            // Outgoing characters, 8 bits per port.
  input  wire [1:0]                 tx_in_solicited;       // Character answers a command.
  input  wire [1:0]                 tx_in_valid;
  output wire [1:0]                 tx_in_ready;
  output reg  [15:0]                tx_out_data;           // Characters to the serialiser.
  output reg  [1:0]                 tx_out_parity;         // Even parity bit, used in 7E1.
  output wire [1:0]                 tx_out_valid;
  input  wire [1:0]                 tx_out_ready;
  input  wire [15:0]                rx_char;               // Received characters.
  input  wire [1:0]                 rx_valid;
  output reg  [15:0]                echo_data;             // Characters to echo.
  output reg  [1:0]                 echo_valid;
  input  wire [1:0]                 cmd_valid;             // A parsed command line.
  input  wire [1:0]                 cmd_is_help;
  input  wire [1:0]                 cmd_id_present;
  input  wire [19:0]                cmd_id;                // Identifier per port, 10 bits.
  input  wire [1:0]                 pw_ok;                 // Valid password received.
  output reg  [1:0]                 cmd_accept;            // Command may execute.
  output reg  [1:0]                 prompt_req;            // Emit a prompt.
  input  wire [1:0]                 cts_in;                // Clear to send from the line.
  output reg  [1:0]                 dtr_out;
  output reg  [1:0]                 rts_out;
  output reg  [1:0]                 modem_init_req;        // Send the modem init string.
  output reg  [1:0]                 rs485_en;
  output reg  [1:0]                 multidrop_en;
  output reg  [1:0]                 frame_7e1;
  output reg  [1:0]                 parity_fix_enable;
  output wire [15:0]                baud_div_first;        // First port bit-time divisor.

  localparam [31:0] BAUD_DIV_FULL = `SPMC_BAUD_DIV;  // Divisor at its natural width, cut below.
  assign baud_div_first = BAUD_DIV_FULL[15:0];

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      reg [`SPMC_MODE_W-1:0] mode_ff;      // This port's mode word.
      reg                    unlocked_ff;  // Password accepted.
      reg                    xoff_ff;      // Far side asked to pause.
      reg                    modem_prev_ff; // Modem bit as it stood one cycle ago.
      wire [7:0]             q_data;
      wire                   q_sol;
      wire                   q_valid;
      wire                   q_ready;
      wire                   q_in_ready;
      wire [7:0]             in_ch = tx_in_data[8*p +: 8];
      wire [7:0]             rx_ch = rx_char[8*p +: 8];
      wire                   drop;
      wire                   sw_flow = mode_ff[`SPMC_BIT_SWFLOW];
      wire                   hw_flow = mode_ff[`SPMC_BIT_HWFLOW];
      wire                   is_flow_ch;
      wire                   id_ok;
      reg  [`SPMC_MODE_W-1:0] sum;
      integer                i;

      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          mode_ff <= `SPMC_MODE_RST;
        end else if (cfg_wr && (cfg_port == p)) begin
          mode_ff <= cfg_mode & `SPMC_MODE_MASK;
        end
      end

      always @* begin
        sum = {`SPMC_MODE_W{1'b0}};
        for (i = 0; i < `SPMC_MODE_W; i = i + 1) begin
          if (mode_ff[i]) begin
            sum = sum + (13'h0_001 << i);
          end
        end
      end
      assign combined_config_code[`SPMC_MODE_W*p +: `SPMC_MODE_W] = sum;

      assign drop = mode_ff[`SPMC_BIT_QUIET] && !tx_in_solicited[p];

      // Dropped characters are taken at once so the source never stalls on them.
      assign tx_in_ready[p] = drop || q_in_ready;

      spmc_fifo #(
        .WIDTH (9),
        .DEPTH (DEPTH),
        .AW    (AW)
      ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_data   ({tx_in_solicited[p], in_ch}),
        .in_valid  (tx_in_valid[p] && !drop),
        .in_ready  (q_in_ready),
        .out_data  ({q_sol, q_data}),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .one_deep  (!mode_ff[`SPMC_BIT_QUEUE])
      );

      assign is_flow_ch = sw_flow && rx_valid[p] &&
                          ((rx_ch == `SPMC_CHAR_XON) || (rx_ch == `SPMC_CHAR_XOFF));

      // Track the pause request from the far side; flow control off clears it.
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          xoff_ff <= 1'b0;
        end else if (!sw_flow) begin
          xoff_ff <= 1'b0;
        end else if (is_flow_ch) begin
          xoff_ff <= (rx_ch == `SPMC_CHAR_XOFF);
        end
      end

      assign tx_out_valid[p] = q_valid && !xoff_ff && !(hw_flow && !cts_in[p]);
      assign q_ready         = tx_out_ready[p] && !xoff_ff && !(hw_flow && !cts_in[p]);

      always @* begin
        if (mode_ff[`SPMC_BIT_FRAME7E1]) begin
          tx_out_data[8*p +: 8] = {1'b0, q_data[6:0]};
          tx_out_parity[p]      = ^q_data[6:0];
        end else begin
          tx_out_data[8*p +: 8] = q_data;
          tx_out_parity[p]      = 1'b0;
        end
        frame_7e1[p]         = mode_ff[`SPMC_BIT_FRAME7E1];
        parity_fix_enable[p] = mode_ff[`SPMC_BIT_PARFIX];
      end

      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          echo_valid[p]       <= 1'b0;
          echo_data[8*p +: 8] <= 8'h00;
        end else begin
          echo_valid[p]       <= rx_valid[p] && !mode_ff[`SPMC_BIT_COMPUTER] && !is_flow_ch;
          echo_data[8*p +: 8] <= rx_ch;
        end
      end

      always @* begin
        rs485_en[p]     = (p == 1) && mode_ff[`SPMC_BIT_RS485];
        multidrop_en[p] = mode_ff[`SPMC_BIT_MULTIDROP] && !rs485_en[p];
      end

      assign id_ok = !multidrop_en[p] || (cmd_id_present[p] && (cmd_id[10*p +: 10] == OWN_ID));

      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          unlocked_ff <= 1'b0;
        end else if (!mode_ff[`SPMC_BIT_PWGATE]) begin
          unlocked_ff <= 1'b0;
        end else if (pw_ok[p]) begin
          unlocked_ff <= 1'b1;
        end
      end

      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          cmd_accept[p] <= 1'b0;
          prompt_req[p] <= 1'b0;
        end else begin
          cmd_accept[p] <= cmd_valid[p] && id_ok &&
                           (!mode_ff[`SPMC_BIT_PWGATE] || unlocked_ff || cmd_is_help[p]);
          prompt_req[p] <= cmd_valid[p] && id_ok && mode_ff[`SPMC_BIT_PROMPT] &&
                           !mode_ff[`SPMC_BIT_COMPUTER];
        end
      end

      // Pulses once each time the modem bit turns on, so a word loaded after power-up still fires.
      // modem init
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          modem_prev_ff     <= 1'b0;
          modem_init_req[p] <= 1'b0;
          dtr_out[p]        <= 1'b0;
          rts_out[p]        <= 1'b0;
        end else begin
          modem_prev_ff     <= mode_ff[`SPMC_BIT_MODEM];
          modem_init_req[p] <= mode_ff[`SPMC_BIT_MODEM] && !modem_prev_ff;
          dtr_out[p]        <= mode_ff[`SPMC_BIT_MODEM] || hw_flow;
          rts_out[p]        <= mode_ff[`SPMC_BIT_MODEM] || (hw_flow && q_valid);
        end
      end
    end
  endgenerate
endmodule // spmc_mode_cfg

// ==== sim/spmc_mode_cfg_checker.sv ====
// Ties the mode block's outputs to the stored mode words and to its inputs.
module spmc_mode_cfg_checker #(
  parameter [9:0] OWN_ID = 10'h1_2D  // Arbitrary default identifier.
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        cfg_wr,
  input wire logic        cfg_port,
  input wire logic [12:0] cfg_mode,
  input wire logic [25:0] combined_config_code,
  input wire logic [1:0]  rx_valid,
  input wire logic [1:0]  echo_valid,
  input wire logic [1:0]  cmd_valid,
  input wire logic [1:0]  cmd_is_help,
  input wire logic [1:0]  cmd_id_present,
  input wire logic [19:0] cmd_id,
  input wire logic [1:0]  cmd_accept,
  input wire logic [1:0]  rs485_en,
  input wire logic [15:0] tx_out_data,
  input wire logic [1:0]  tx_out_parity,
  input wire logic [1:0]  tx_out_valid,
  input wire logic [1:0]  frame_7e1,
  input wire logic [1:0]  modem_init_req,
  input wire logic [1:0]  cts_in
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire [12:0] m0 = combined_config_code[12:0];  // Mode word of the first port.
  wire [12:0] m1 = combined_config_code[25:13]; // Mode word of the second port.
  a_code_sum: assert property (cfg_wr && !cfg_port |=> m0 == ($past(cfg_mode) & 13'h1_FEF))
    else $error("Mode sum differs from the written word.");
  a_port_keep: assert property (cfg_wr && cfg_port |=> $stable(m0))
    else $error("Second port write moved the first port.");
  a_echo_off: assert property (rx_valid[0] && m0[1] |=> !echo_valid[0])
    else $error("Echo seen in computer mode.");
  a_help_pass: assert property (cmd_valid[0] && cmd_is_help[0] && !m0[5] |=> cmd_accept[0])
    else $error("Help request refused.");
  a_id_refuse: assert property (cmd_valid[0] && m0[5] && !(cmd_id_present[0] && cmd_id[9:0] == OWN_ID)
    |=> !cmd_accept[0])
    else $error("Foreign identifier accepted.");
  a_rs485_first: assert property (rs485_en == {m1[10], 1'b0})
    else $error("Half duplex flag wrong.");
  a_frame_even: assert property (tx_out_valid[0] && frame_7e1[0]
    |-> !tx_out_data[7] && tx_out_parity[0] == ^tx_out_data[6:0])
    else $error("Seven bit framing wrong.");
  a_cts_hold: assert property ((m0[3] && !cts_in[0]) [*2] |-> !tx_out_valid[0])
    else $error("Output offered without clear to send.");
  a_modem_pulse: assert property (modem_init_req[0] |=> !modem_init_req[0])
    else $error("Modem init request held longer than one cycle.");
endmodule // spmc_mode_cfg_checker

bind spmc_mode_cfg spmc_mode_cfg_checker #(.OWN_ID(OWN_ID)) u_chk (
  .clk, .nrst, .cfg_wr, .cfg_port, .cfg_mode, .combined_config_code, .rx_valid, .echo_valid,
  .cmd_valid, .cmd_is_help, .cmd_id_present, .cmd_id, .cmd_accept, .rs485_en, .tx_out_data,
  .tx_out_parity, .tx_out_valid, .frame_7e1, .modem_init_req, .cts_in
);

// ==== sim/spmc_far_end.sv ====
// Remote reader of the first port's characters; it can be stalled.
module spmc_far_end (
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic       vld,
  input  wire logic [7:0] dat,
  output logic            rdy,
  output logic [7:0]      last,
  output int              cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Ready is withdrawn while stalled.
  assign rdy = !stall;
  initial cnt = 0;
  // Each accepted character is kept and counted.
  always @(posedge clk) begin
    if (vld && rdy) begin
      last <= dat;
      cnt  <= cnt + 1;
    end
  end
endmodule // spmc_far_end

// ==== sim/spmc_tb.sv ====
// Drives both ports' mode words and the first port's traffic.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] ID = 10'h155; // Identifier given to this instance.
  logic        clk, nrst, cfg_wr, cfg_port, stall, far_rdy;
  logic [12:0] cfg_mode;
  logic [25:0] combined_config_code;
  logic [15:0] tx_in_data, tx_out_data, rx_char, echo_data, baud_div_first;
  logic [19:0] cmd_id;
  logic [1:0]  tx_in_solicited, tx_in_valid, tx_in_ready, tx_out_parity, tx_out_valid, tx_out_ready;
  logic [1:0]  rx_valid, echo_valid, cmd_valid, cmd_is_help, cmd_id_present, pw_ok, cmd_accept;
  logic [1:0]  prompt_req, cts_in, dtr_out, rts_out, modem_init_req, rs485_en, multidrop_en;
  logic [1:0]  frame_7e1, parity_fix_enable;
  logic [7:0]  far_last;
  int          far_cnt, c0, mismatches = 0, check_count = 0;
  assign tx_out_ready = {1'b1, far_rdy};
  initial clk = 0;
  always #5 clk = ~clk;
  spmc_mode_cfg #(.OWN_ID(ID)) dut (
    .clk, .nrst, .cfg_wr, .cfg_port, .cfg_mode, .combined_config_code, .tx_in_data, .tx_in_solicited,
    .tx_in_valid, .tx_in_ready, .tx_out_data, .tx_out_parity, .tx_out_valid, .tx_out_ready, .rx_char,
    .rx_valid, .echo_data, .echo_valid, .cmd_valid, .cmd_is_help, .cmd_id_present, .cmd_id, .pw_ok,
    .cmd_accept, .prompt_req, .cts_in, .dtr_out, .rts_out, .modem_init_req, .rs485_en, .multidrop_en,
    .frame_7e1, .parity_fix_enable, .baud_div_first
  );
  spmc_far_end far (.clk, .stall, .vld(tx_out_valid[0]), .dat(tx_out_data[7:0]), .rdy(far_rdy),
    .last(far_last), .cnt(far_cnt));
  task chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic p, input logic [12:0] m);
    cfg_wr = 1;
    cfg_port = p;
    cfg_mode = m;
    @(negedge clk);
    cfg_wr = 0;
    @(negedge clk);
  endtask
  task put(input logic [7:0] d, input logic s);
    c0 = far_cnt;
    tx_in_data[7:0] = d;
    tx_in_solicited[0] = s;
    tx_in_valid[0] = 1;
    @(negedge clk);
    tx_in_valid[0] = 0;
  endtask
  task drain(input int e);
    for (int k = 0; k < 40 && tx_out_valid[0] === 1'b1; k++) @(negedge clk);
    @(negedge clk);
    chk(far_cnt - c0, e);
  endtask
  task rx(input logic [7:0] d);
    rx_char[7:0] = d;
    rx_valid[0] = 1;
    @(negedge clk);
    rx_valid[0] = 0;
  endtask
  task cmd(input logic h, i_ok, e, p);
    cmd_valid[0] = 1;
    cmd_is_help[0] = h;
    cmd_id_present[0] = 1;
    cmd_id[9:0] = i_ok ? ID : ~ID;
    @(negedge clk);
    cmd_valid[0] = 0;
    chk(cmd_accept[0], e);
    chk(prompt_req[0], p);
    @(negedge clk);
  endtask
  task t_reset;
    chk(combined_config_code, {13'h0380, 13'h0380});
    chk(parity_fix_enable, 2'b11);
    chk(baud_div_first, 16'h1458);
    chk(frame_7e1, 2'b00);
    chk(modem_init_req, 2'b00);
    $display("t_reset done");
  endtask
  task t_sum;
    wr(1, 13'h0023);
    chk(combined_config_code[25:13], 13'h0023);
    chk(combined_config_code[12:0], 13'h0380);
    for (int i = 0; i < 13; i++) begin
      wr(0, 13'h0001 << i);
      chk(combined_config_code[12:0], (13'h0001 << i) & 13'h1_FEF);
      if (i == 6) chk(dtr_out[0], 1'b1);
      if (i == 6) chk(modem_init_req, 2'b01);
      if (i == 7) chk(modem_init_req, 2'b00);
      if (i == 7) chk(parity_fix_enable, 2'b01);
      if (i == 10) chk(rs485_en, 2'b00);
      if (i == 11) chk(frame_7e1, 2'b01);
    end
    chk(combined_config_code[25:13], 13'h0023);
    wr(1, 13'h0420);
    chk(rs485_en, 2'b10);
    chk(multidrop_en, 2'b00);
    $display("t_sum done");
  endtask
  task t_echo;
    wr(0, 13'h0000);
    rx(8'h41);
    chk(echo_valid[0], 1'b1);
    chk(echo_data[7:0], 8'h41);
    wr(0, 13'h0002);
    rx(8'h41);
    chk(echo_valid[0], 1'b0);
    $display("t_echo done");
  endtask
  task t_cmd;
    wr(0, 13'h0020);
    chk(multidrop_en, 2'b01);
    cmd(0, 0, 0, 0);
    cmd(0, 1, 1, 0);
    wr(0, 13'h0004);
    cmd(0, 1, 0, 0);
    cmd(1, 1, 1, 0);
    pw_ok[0] = 1;
    @(negedge clk);
    pw_ok[0] = 0;
    @(negedge clk);
    cmd(0, 1, 1, 0);
    wr(0, 13'h1000);
    cmd(0, 1, 1, 1);
    $display("t_cmd done");
  endtask
  task t_flow;
    int n;
    for (int m = 0; m < 2; m++) begin
      wr(0, m ? 13'h0200 : 13'h0000);
      stall = 1;
      c0 = far_cnt;
      for (n = 0; n < 20 && tx_in_ready[0] === 1'b1; n++) begin
        tx_in_data[7:0] = 8'h30 + n[7:0];
        tx_in_valid[0] = 1;
        @(negedge clk);
      end
      tx_in_valid[0] = 0;
      chk(n, m ? 16 : 1);
      stall = 0;
      drain(n);
      chk(far_last, 8'h2F + n[7:0]);
    end
    $display("t_flow done");
  endtask
  task t_line;
    wr(0, 13'h0001);
    put(8'h41, 0);
    drain(0);
    put(8'h42, 1);
    drain(1);
    wr(0, 13'h0100);
    rx(8'h13);
    chk(echo_valid[0], 1'b0);
    put(8'h43, 0);
    drain(0);
    rx(8'h11);
    drain(1);
    wr(0, 13'h0008);
    cts_in[0] = 0;
    put(8'h44, 0);
    drain(0);
    chk(rts_out[0], 1'b1);
    chk(dtr_out[0], 1'b1);
    cts_in[0] = 1;
    drain(1);
    wr(0, 13'h0800);
    put(8'hC3, 0);
    chk(tx_out_parity[0], 1'b1);
    drain(1);
    chk(far_last, 8'h43);
    $display("t_line done");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Cuts a hang short well after all tests should have ended.
  initial begin
    #40000;
    mismatches++;
    end_sim;
  end
  // Holds reset for sixteen cycles, then runs every test once.
  initial begin
    {cfg_wr, cfg_port, cfg_mode, tx_in_data, tx_in_solicited, tx_in_valid} = '0;
    {rx_char, rx_valid, cmd_valid, cmd_is_help, cmd_id_present, cmd_id, pw_ok} = '0;
    cts_in = 2'b11;
    stall = 0;
    nrst = 0;
    repeat (16) @(negedge clk);
    nrst = 1;
    @(negedge clk);
    t_reset;
    t_sum;
    t_echo;
    t_cmd;
    t_flow;
    t_line;
    end_sim;
  end
endmodule // testbench
